// File: design/mox_pkg.sv
// constants shared by the move-or-load instruction executor
package mox_pkg;
	// ****************************************
	// widths
	// ****************************************
	localparam int unsigned DATA_W = 8;
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned WORD_W = 16;
	localparam int unsigned REG_AW = 4;
	localparam int unsigned RDATA_W = 16;
	localparam int unsigned PTR_COUNT = 3;

	// ****************************************
	// instruction encodings
	// ****************************************
	localparam logic [5:0] ENC_OR_WITH_FILE = 6'h04;
	localparam logic [5:0] ENC_FILE_TO_DEST_MOVE = 6'h14;
	localparam logic [9:0] ENC_POINTER_LOAD_HI = 10'h3b8;
	localparam logic [7:0] ENC_POINTER_LOAD_LO = 8'hf0;
	localparam logic [3:0] ENC_MEM_MOVE_SRC = 4'hc;
	localparam logic [3:0] ENC_MEM_MOVE_DST = 4'hf;
	localparam logic [7:0] ENC_BANK_SELECT_LOAD = 8'h01;
	localparam int unsigned BIT_DEST = 9;
	localparam int unsigned BIT_ACCESS = 8;

	// ****************************************
	// data space layout
	// ****************************************
	localparam logic [7:0] INDEXED_MAX = 8'h5f;
	localparam logic [7:0] ACCESS_LOW_MAX = 8'h5f;
	localparam logic [3:0] ACCESS_HIGH_PAGE = 4'hf;
	localparam logic [3:0] ACCESS_LOW_PAGE = 4'h0;
	localparam logic [11:0] WORKING_ADDR = 12'hfe8;
	localparam logic [1:0] INDEX_PTR = 2'h2;

	// ****************************************
	// register port offsets and reset values
	// ****************************************
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_WORKING = 4'h1;
	localparam logic [3:0] OFS_BANK_SELECT = 4'h2;
	localparam logic [3:0] OFS_FLAGS = 4'h3;
	localparam logic [3:0] OFS_POINTER0 = 4'h4;
	localparam logic [3:0] OFS_POINTER1 = 4'h5;
	localparam logic [3:0] OFS_POINTER2 = 4'h6;
	localparam int unsigned CTRL_EXT_BIT = 0;
	localparam int unsigned FLAG_ZERO_BIT = 0;
	localparam int unsigned FLAG_NEG_BIT = 1;
	localparam logic RST_EXT_EN = 1'b0;
	localparam logic [7:0] RST_WORKING = 8'h00;
	localparam logic [3:0] RST_BANK = 4'h0;
	localparam logic [11:0] RST_POINTER = 12'h000;
endpackage

// File: design/mox_data_mem.sv
// byte-wide data space: one synchronous write port, one combinational read port
`timescale 1ns/1ps
`default_nettype none
module mox_data_mem
#(
	parameter int unsigned AW = 12,
	parameter int unsigned DW = 8
)
(
	input  wire logic          clk,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [DW-1:0] wdata,
	input  wire logic [AW-1:0] raddr,
	output logic      [DW-1:0] rdata
);
	// no reset: contents are undefined until written, as in real sram
	logic [DW-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge clk)
	begin
		if (we)
		begin
			mem[waddr] <= wdata;
		end
	end

	assign rdata = mem[raddr];
endmodule
`default_nettype wire

// File: design/mox_exec.sv
// executor for or-with-file, file move, pointer load, memory move and bank select load
//
// Overview of operation
// RQ1: or_with_file ors working register with file, updates negative and zero.
// RQ2: result is bitwise inclusive or, sent to destination picked by d.
// RQ3: destination bit 0 writes the result to the working register.
// RQ4: destination bit 1 writes the result back to the file register.
// RQ5: access bit 0 uses access bank; 1 takes page from bank_select_reg.
// RQ6: access 0, extended set on, address up to 95: indexed literal offset.
// RQ7: file_to_dest_move copies file to destination, updates flags, one word.
// RQ8: pointer_literal_load puts 12-bit literal in chosen file_pointer_reg, flags kept.
// RQ9: pointer load is two words; high four bits written first, low byte second.
// RQ10: mem_to_mem_move copies one full 12-bit address to another, flags kept.
// RQ11: first word 1100 carries source, second word 1111 carries destination.
// RQ12: source read in first cycle, destination written in last quarter of second.
// RQ13: working register may be source or destination of the memory move.
// RQ14: software never targets counter low or stack top bytes with memory move.
// RQ15: bank_select_load keeps only the low nibble; upper bits read zero.
// RQ16: negative is result bit 7; zero set when the result is all zeros.
`timescale 1ns/1ps
`default_nettype none
module mox_exec
(
	input  wire logic                         clk,
	input  wire logic                         resetn,
	input  wire logic [mox_pkg::WORD_W-1:0]   instr_word,
	input  wire logic                         instr_valid,
	output logic                              instr_take,
	input  wire logic [mox_pkg::REG_AW-1:0]   reg_addr,
	input  wire logic [7:0]                   reg_wdata,
	input  wire logic                         reg_wr,
	input  wire logic                         reg_rd,
	output logic      [mox_pkg::RDATA_W-1:0]  reg_rdata
);
	// ****************************************
	// types
	// ****************************************
	typedef enum logic [3:0]
	{
		PH_Q1 = 4'b0001,
		PH_Q2 = 4'b0010,
		PH_Q3 = 4'b0100,
		PH_Q4 = 4'b1000
	} mox_phase_e;

	typedef enum logic [7:0]
	{
		OP_NONE = 8'h01,
		OP_OR   = 8'h02,
		OP_MOVE = 8'h04,
		OP_PTR1 = 8'h08,
		OP_PTR2 = 8'h10,
		OP_MEM1 = 8'h20,
		OP_MEM2 = 8'h40,
		OP_BANK = 8'h80
	} mox_op_e;

	typedef struct packed
	{
		mox_phase_e                             phase;
		mox_op_e                                op;
		logic                                   second;
		logic [mox_pkg::WORD_W-1:0]             ir;
		logic [1:0]                             psel;
		logic [mox_pkg::ADDR_W-1:0]             addr;
		logic [mox_pkg::DATA_W-1:0]             opnd;
		logic [mox_pkg::DATA_W-1:0]             res;
		logic [mox_pkg::DATA_W-1:0]             w;
		logic [3:0]                             bank_select_reg;
		logic                                   neg;
		logic                                   zero;
		logic [mox_pkg::PTR_COUNT-1:0][mox_pkg::ADDR_W-1:0] file_pointer_reg;
		logic                                   ext_en;
		logic                                   take;
		logic [mox_pkg::RDATA_W-1:0]            rdata;
	} mox_state_s;

	// ****************************************
	// functions
	// ****************************************
	function automatic logic [mox_pkg::ADDR_W-1:0] eff_addr
	(
		input logic [7:0]                  f,
		input logic                        a,
		input logic                        ext,
		input logic [3:0]                  bank,
		input logic [mox_pkg::ADDR_W-1:0]  base
	);
		logic [mox_pkg::ADDR_W-1:0] sum;
		sum = base + {4'h0, f};
		if (a)
			return {bank, f};  // [RQ5]
		if (ext && f <= mox_pkg::INDEXED_MAX)
			return sum;  // [RQ6]
		if (f <= mox_pkg::ACCESS_LOW_MAX)
			return {mox_pkg::ACCESS_LOW_PAGE, f};  // [RQ5]
		return {mox_pkg::ACCESS_HIGH_PAGE, f};  // [RQ5]
	endfunction

	function automatic logic byte_op(input mox_op_e op);
		return (op == OP_OR) || (op == OP_MOVE);
	endfunction

	// ****************************************
	// state and data memory
	// ****************************************
	mox_state_s                  r;
	mox_state_s                  next_r;
	logic                        mem_we;
	logic [mox_pkg::ADDR_W-1:0]  mem_waddr;
	logic [mox_pkg::DATA_W-1:0]  mem_wdata;
	logic [mox_pkg::DATA_W-1:0]  mem_rdata;
	logic [mox_pkg::DATA_W-1:0]  rd_val;
	logic                        to_working;

	mox_data_mem
	#(
		.AW (mox_pkg::ADDR_W),
		.DW (mox_pkg::DATA_W)
	)
	u_mem
	(
		.clk   (clk),
		.we    (mem_we),
		.waddr (mem_waddr),
		.wdata (mem_wdata),
		.raddr (r.addr),
		.rdata (mem_rdata)
	);

	// the working register lives here, so its data-space address is steered away
	assign rd_val = (r.addr == mox_pkg::WORKING_ADDR) ? r.w : mem_rdata;  // [RQ13]
	assign to_working = r.addr == mox_pkg::WORKING_ADDR;

	// ****************************************
	// data space write in the last quarter
	// ****************************************
	always_comb
	begin
		mem_we = 1'b0;
		mem_waddr = r.addr;
		mem_wdata = r.res;
		if (r.phase == PH_Q4 && !to_working)
		begin
			if (byte_op(r.op) && r.ir[mox_pkg::BIT_DEST])
				mem_we = 1'b1;  // [RQ4]
			if (r.op == OP_MEM2)
			begin
				mem_we = 1'b1;  // [RQ10] [RQ12]
				mem_wdata = r.opnd;
			end
		end
	end

	// ****************************************
	// next state
	// ****************************************
	always_comb
	begin
		next_r = r;
		next_r.take = 1'b0;
		next_r.rdata = '0;
		unique case (r.phase)
			PH_Q1:
			begin
				next_r.phase = PH_Q2;
				next_r.op = OP_NONE;
				if (instr_valid)
				begin
					next_r.ir = instr_word;
					next_r.take = 1'b1;
					next_r.second = 1'b0;
					if (r.second)
					begin
						// a stray word where the second half is due ends the pair as a no-op
						if (r.op == OP_PTR1 && instr_word[15:8] == mox_pkg::ENC_POINTER_LOAD_LO)
							next_r.op = OP_PTR2;  // [RQ9]
						else if (r.op == OP_MEM1 && instr_word[15:12] == mox_pkg::ENC_MEM_MOVE_DST)
						begin
							next_r.op = OP_MEM2;  // [RQ11]
							next_r.addr = instr_word[11:0];
						end
					end
					else if (instr_word[15:10] == mox_pkg::ENC_OR_WITH_FILE
						|| instr_word[15:10] == mox_pkg::ENC_FILE_TO_DEST_MOVE)
					begin
						next_r.op = (instr_word[15:10] == mox_pkg::ENC_OR_WITH_FILE)
							? OP_OR : OP_MOVE;  // [RQ1] [RQ7]
						next_r.addr = eff_addr(instr_word[7:0], instr_word[mox_pkg::BIT_ACCESS],
							r.ext_en, r.bank_select_reg,
							r.file_pointer_reg[mox_pkg::INDEX_PTR]);  // [RQ5] [RQ6]
					end
					else if (instr_word[15:6] == mox_pkg::ENC_POINTER_LOAD_HI)
					begin
						next_r.op = OP_PTR1;  // [RQ9]
						next_r.psel = instr_word[5:4];
						next_r.second = 1'b1;
					end
					else if (instr_word[15:12] == mox_pkg::ENC_MEM_MOVE_SRC)
					begin
						next_r.op = OP_MEM1;  // [RQ11]
						next_r.addr = instr_word[11:0];
						next_r.second = 1'b1;
					end
					else if (instr_word[15:8] == mox_pkg::ENC_BANK_SELECT_LOAD)
						next_r.op = OP_BANK;
				end
				else
					next_r.op = r.second ? r.op : OP_NONE;  // [RQ9] [RQ11]
				// a late second word keeps the pair waiting; the first half repeats harmlessly
			end
			PH_Q2:
			begin
				next_r.phase = PH_Q3;
				if (byte_op(r.op) || r.op == OP_MEM1)
					next_r.opnd = rd_val;  // [RQ12] [RQ13]
			end
			PH_Q3:
			begin
				next_r.phase = PH_Q4;
				if (r.op == OP_OR)
					next_r.res = r.w | r.opnd;  // [RQ2]
				else
					next_r.res = r.opnd;  // [RQ7]
			end
			PH_Q4:
			begin
				next_r.phase = PH_Q1;
				if (byte_op(r.op))
				begin
					next_r.neg = r.res[7];  // [RQ16]
					next_r.zero = (r.res == 8'h00);  // [RQ16]
					if (!r.ir[mox_pkg::BIT_DEST] || to_working)
						next_r.w = r.res;  // [RQ3] [RQ4]
				end
				// flags are untouched by the pointer, memory and bank loads
				if (r.op == OP_PTR1 && r.psel < 2'(mox_pkg::PTR_COUNT))
					next_r.file_pointer_reg[r.psel][11:8] = r.ir[3:0];  // [RQ8] [RQ9]
				if (r.op == OP_PTR2 && r.psel < 2'(mox_pkg::PTR_COUNT))
					next_r.file_pointer_reg[r.psel][7:0] = r.ir[7:0];  // [RQ8] [RQ9]
				if (r.op == OP_MEM2 && to_working)
					next_r.w = r.opnd;  // [RQ13]
				if (r.op == OP_BANK)
					next_r.bank_select_reg = r.ir[3:0];  // [RQ15]
			end
		endcase
		if (reg_wr && reg_addr == mox_pkg::OFS_CTRL)
			next_r.ext_en = reg_wdata[mox_pkg::CTRL_EXT_BIT];
		if (reg_rd)
		begin
			unique case (reg_addr)
				mox_pkg::OFS_CTRL:        next_r.rdata[mox_pkg::CTRL_EXT_BIT] = r.ext_en;
				mox_pkg::OFS_WORKING:     next_r.rdata[7:0] = r.w;
				mox_pkg::OFS_BANK_SELECT: next_r.rdata[3:0] = r.bank_select_reg;  // [RQ15]
				mox_pkg::OFS_FLAGS:
				begin
					next_r.rdata[mox_pkg::FLAG_NEG_BIT] = r.neg;
					next_r.rdata[mox_pkg::FLAG_ZERO_BIT] = r.zero;
				end
				mox_pkg::OFS_POINTER0:    next_r.rdata[11:0] = r.file_pointer_reg[0];
				mox_pkg::OFS_POINTER1:    next_r.rdata[11:0] = r.file_pointer_reg[1];
				mox_pkg::OFS_POINTER2:    next_r.rdata[11:0] = r.file_pointer_reg[2];
				default:                  next_r.rdata = '0;
			endcase
		end
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			r <= '0;
			r.phase <= PH_Q1;
			r.op <= OP_NONE;
			r.w <= mox_pkg::RST_WORKING;
			r.bank_select_reg <= mox_pkg::RST_BANK;
			r.file_pointer_reg <= {mox_pkg::PTR_COUNT{mox_pkg::RST_POINTER}};
			r.ext_en <= mox_pkg::RST_EXT_EN;
		end
		else
		begin
			r <= next_r;
		end
	end

	assign instr_take = r.take;
	assign reg_rdata = r.rdata;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	chk_or_result: assert property ( // [RQ1] [RQ2]
		(r.phase == PH_Q2 && r.op == OP_OR && !r.ir[mox_pkg::BIT_DEST] && !to_working)
		##2 1 |=> r.w == ($past(r.w, 3) | $past(rd_val, 3)))
		else $error("or result not in working register");

	chk_dest_working: assert property ( // [RQ3]
		(r.phase == PH_Q4 && byte_op(r.op) && !r.ir[mox_pkg::BIT_DEST]) |-> !mem_we)
		else $error("file written with destination bit clear");

	chk_dest_file: assert property ( // [RQ4]
		(r.phase == PH_Q4 && byte_op(r.op) && r.ir[mox_pkg::BIT_DEST] && !to_working)
		|-> mem_we && mem_waddr == r.addr && mem_wdata == r.res)
		else $error("file not written back");

	chk_bank_page: assert property ( // [RQ5]
		(r.phase == PH_Q2 && byte_op(r.op) && r.ir[mox_pkg::BIT_ACCESS])
		|-> r.addr == {r.bank_select_reg, r.ir[7:0]})
		else $error("banked address wrong");

	chk_indexed_addr: assert property ( // [RQ6]
		(r.phase == PH_Q2 && byte_op(r.op) && !r.ir[mox_pkg::BIT_ACCESS]
		&& $past(r.ext_en) && r.ir[7:0] <= mox_pkg::INDEXED_MAX)
		|-> r.addr == 12'(r.file_pointer_reg[mox_pkg::INDEX_PTR] + {4'h0, r.ir[7:0]}))
		else $error("indexed offset address wrong");

	chk_flags_nz: assert property ( // [RQ7] [RQ16]
		(r.phase == PH_Q4 && byte_op(r.op))
		|=> r.neg == $past(r.res[7]) && r.zero == ($past(r.res) == 8'h00))
		else $error("negative or zero flag wrong");

	chk_ptr_flags: assert property ( // [RQ8] [RQ10]
		(r.phase == PH_Q4 && (r.op == OP_PTR1 || r.op == OP_PTR2 || r.op == OP_MEM2
		|| r.op == OP_BANK)) |=> $stable(r.neg) && $stable(r.zero))
		else $error("flags changed by a load");

	chk_ptr_low: assert property ( // [RQ9]
		(r.phase == PH_Q4 && r.op == OP_PTR2 && r.psel == mox_pkg::INDEX_PTR)
		|=> r.file_pointer_reg[mox_pkg::INDEX_PTR]
		== {$past(r.file_pointer_reg[mox_pkg::INDEX_PTR][11:8]), $past(r.ir[7:0])})
		else $error("pointer low byte not loaded");

	chk_mem_move: assert property ( // [RQ10] [RQ12]
		(r.phase == PH_Q4 && r.op == OP_MEM2 && !to_working)
		|-> mem_we && mem_wdata == r.opnd && mem_waddr == r.ir[11:0])
		else $error("memory move write wrong");

	chk_bank_nibble: assert property ( // [RQ15]
		(r.phase == PH_Q4 && r.op == OP_BANK) |=> r.bank_select_reg == $past(r.ir[3:0]))
		else $error("bank select load wrong");

	cov_or_file: cover property (r.phase == PH_Q4 && r.op == OP_OR && mem_we);
	cov_ptr_pair: cover property (r.phase == PH_Q4 && r.op == OP_PTR2);
	cov_mem_move: cover property (r.phase == PH_Q4 && r.op == OP_MEM2);
	cov_indexed: cover property (r.phase == PH_Q2 && byte_op(r.op) && r.ext_en
		&& !r.ir[mox_pkg::BIT_ACCESS] && r.ir[7:0] <= mox_pkg::INDEXED_MAX);
endmodule
`default_nettype wire

// File: tb/mox_tb_pkg.sv
// record of the last data memory write seen by the spy
package mox_tb_pkg;
	logic [11:0] wa;
	logic [7:0]  wd;
	int          nw;
endpackage

// File: tb/mox_spy.sv
// watcher bound to the data memory, records every write
`timescale 1ns/1ps
`default_nettype none
module mox_spy
(
	input wire logic        clk,
	input wire logic        we,
	input wire logic [11:0] waddr,
	input wire logic [7:0]  wdata
);
	always @(posedge clk)
	begin
		if (we === 1'b1)
		begin
			mox_tb_pkg::wa = waddr;
			mox_tb_pkg::wd = wdata;
			mox_tb_pkg::nw++;
		end
	end
endmodule
bind mox_data_mem mox_spy i_mox_spy (.clk(clk), .we(we), .waddr(waddr), .wdata(wdata));
`default_nettype wire

// File: tb/mox_fetch.sv
// program fetch model: hands queued instruction words to the executor
`timescale 1ns/1ps
`default_nettype none
module mox_fetch
(
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        instr_take,
	output logic      [15:0] instr_word,
	output logic             instr_valid,
	output logic             pending
);
	logic [15:0] q [$];

	task automatic push(input logic [15:0] w);
		q.push_back(w);
	endtask

	// a word stands until its take pulse; the second word of a pair may be queued later
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			instr_valid <= 1'b0;
			instr_word  <= 16'h0000;
			pending     <= 1'b0;
		end
		else
		begin
			if (instr_take === 1'b1 && q.size() != 0)
				void'(q.pop_front());
			pending     <= (q.size() != 0);
			instr_valid <= (q.size() != 0);
			// idle bus toggles so a stale word never passes for a fresh one
			instr_word  <= (q.size() != 0) ? q[0] : ~instr_word;
		end
	end
endmodule
`default_nettype wire

// File: tb/mox_exec_test.sv
// self-checking bench for the move-or-load instruction executor
`timescale 1ns/1ps
`default_nettype none
module mox_exec_test;
	// ****************************************
	// signals
	// ****************************************
	// top of data space kept clear of moves; bound is a bench choice
	localparam logic [11:0] GUARD = 12'hff8;
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic        instr_valid;
	logic        instr_take;
	logic        pending;
	logic [15:0] instr_word;
	logic [15:0] reg_rdata;
	logic [3:0]  reg_addr = 4'h0;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] seed = 32'h1e49;
	logic [11:0] ptr [3];
	logic [11:0] fa;
	logic [7:0]  f;
	logic        a;
	logic        e;
	logic        d;
	logic [3:0]  bank;
	int          n_errors = 0;
	int          total_checks = 0;
	int          cycles = 0;
	int          exp_nw = 0;
	int          i;

	always #4 clk = ~clk;

	mox_exec i_mox_exec (.clk(clk), .resetn(resetn), .instr_word(instr_word),
		.instr_valid(instr_valid), .instr_take(instr_take), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	mox_fetch i_mox_fetch (.clk(clk), .resetn(resetn), .instr_take(instr_take),
		.instr_word(instr_word), .instr_valid(instr_valid), .pending(pending));

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] pointer_literal_load(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [11:0] eaddr(input logic [7:0] fv, input logic av,
		input logic ev, input logic [3:0] b, input logic [11:0] p);
		if (av)
			return {b, fv};
		if (ev && fv <= 8'h5f)
			return p + {4'h0, fv};
		return {(fv <= 8'h5f) ? 4'h0 : 4'hf, fv};
	endfunction

	task automatic end_of_test;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic wr(input logic [3:0] ad, input logic [7:0] dv);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= ad;
		reg_wdata <= dv;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic chk_rd(input logic [3:0] ad, input logic [15:0] ex);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= ad;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		total_checks++;
		if (reg_rdata !== ex)
		begin
			n_errors++;
			$display("ERROR reg %0d expected %h seen %h", ad, ex, reg_rdata);
		end
	endtask

	task automatic chk_wr(input logic [11:0] ea, input int inc);
		exp_nw += inc;
		total_checks++;
		if (mox_tb_pkg::wa !== ea || mox_tb_pkg::wd !== 8'h00 || mox_tb_pkg::nw != exp_nw)
		begin
			n_errors++;
			$display("ERROR memwrite expected %h/00/%0d seen %h/%h/%0d", ea, exp_nw,
				mox_tb_pkg::wa, mox_tb_pkg::wd, mox_tb_pkg::nw);
		end
	endtask

	task automatic run(input logic [15:0] w1, input logic [15:0] w2, input int n);
		int k;
		i_mox_fetch.push(w1);
		if (n == 2)
			i_mox_fetch.push(w2);
		repeat (2) @(posedge clk);
		#1;
		for (k = 0; k < 50 && pending === 1'b1; k++)
		begin
			@(posedge clk);
			#1;
		end
		repeat (4) @(posedge clk);
	endtask

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_errors++;
			end_of_test;
		end
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		for (i = 0; i < 16; i++)
			chk_rd(i[3:0], 16'h0000);
		for (i = 0; i < 4; i++)
		begin
			seed = pointer_literal_load(seed);
			run({8'hee, 2'b00, i[1:0], seed[11:8]}, {8'hf0, seed[7:0]}, 2);
			if (i < 3)
				ptr[i] = seed[11:0];
		end
		for (i = 0; i < 3; i++)
			chk_rd(4'h4 + i[3:0], {4'h0, ptr[i]});
		// second word held back: only the high part may have landed
		seed = pointer_literal_load(seed);
		run({8'hee, 4'h1, seed[11:8]}, 16'h0000, 1);
		chk_rd(4'h5, {4'h0, seed[11:8], ptr[1][7:0]});
		run({8'hf0, seed[7:0]}, 16'h0000, 1);
		chk_rd(4'h5, {4'h0, seed[11:0]});
		run({4'hc, mox_pkg::WORKING_ADDR}, {4'hf, 12'h123}, 2);
		chk_wr(12'h123, 1);
		chk_rd(4'h3, 16'h0000);
		for (i = 0; i < 12; i++)
		begin
			seed = pointer_literal_load(seed);
			bank = seed[3:0];
			run({8'h01, seed[7:0]}, 16'h0000, 1);
			chk_rd(4'h2, {12'h000, bank});
			e = (i < 2) | seed[8];
			wr(4'h0, {seed[15:9], e});
			chk_rd(4'h0, {15'h0000, e});
			ptr[2] = seed[27:16];
			run({8'hee, 4'h2, ptr[2][11:8]}, {8'hf0, ptr[2][7:0]}, 2);
			f = (i == 0) ? 8'h5f : (i == 1) ? 8'h60 : seed[31:24];
			a = (i >= 2) & seed[28];
			d = seed[29];
			fa = eaddr(f, a, e, bank, ptr[2]);
			// moves never target the guarded top of the data space
			if (fa < GUARD && fa != mox_pkg::WORKING_ADDR)
			begin
				run({4'hc, mox_pkg::WORKING_ADDR}, {4'hf, fa}, 2);
				chk_wr(fa, 1);
				run({6'h04, d, a, f}, 16'h0000, 1);
				chk_wr(fa, d ? 1 : 0);
				chk_rd(4'h3, 16'h0001);
				run({6'h14, 1'b0, a, f}, 16'h0000, 1);
				chk_wr(fa, 0);
				chk_rd(4'h1, 16'h0000);
				chk_rd(4'h3, 16'h0001);
			end
		end
		end_of_test;
	end
endmodule
`default_nettype wire
